// >>> ubg_cfg.svh
// Register map, field positions, reset values and divider constants
`ifndef UBG_CFG_SVH
`define UBG_CFG_SVH
`define UBG_IDX_BAUD 3'h0
`define UBG_IDX_PRESC 3'h1
`define UBG_IDX_CTRL 3'h2
`define UBG_IDX_STAT 3'h3
`define UBG_BAUD_RESET 8'h00
`define UBG_PRESC_RESET 8'h00
`define UBG_CTRL_ENABLE 0
`define UBG_CTRL_SRC 1
`define UBG_CTRL_LONG 2
`define UBG_CTRL_SEND 3
`define UBG_STAT_BREAK 0
`define UBG_STAT_SENDING 1
`define UBG_BPD_CODE0 4'h1
`define UBG_BPD_CODE1 4'h3
`define UBG_BPD_CODE2 4'h4
`define UBG_BPD_CODE3 4'hD
`define UBG_SAMPLE_LAST 2'h3
`define UBG_BIT_LAST 4'hF
`define UBG_BREAK_NORMAL 4'hA
`define UBG_BREAK_SHORT 4'hB
`define UBG_BREAK_LONG 4'hC
`define UBG_FRAME_LAST 5'h1F
`define UBG_SPREAD_MAX 5'h10
`endif

// >>> ubg_pkg.sv
// Types shared by the baud generator and LIN break logic
package ubg_pkg;
  typedef struct packed {
    logic reserved;
    logic linTxBreakEnable;
    logic linRxBreakEnable;
    logic ratePrescaleHi;
    logic ratePrescaleLo;
    logic [2:0] baudDivisorSelect;
  } ubg_baud_ctl_type;
  typedef struct packed {
    logic [2:0] prescalerDivisorSelect;
    logic [4:0] clockInsertionSelect;
  } ubg_presc_ctl_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_ARM = 2'h1,
    TX_LOW = 2'h3
  } ubg_tx_state_type;
endpackage

// >>> ubg_baud_lin.sv
// Baud rate generator with LIN break detection and generation
//
// Contract
// - LIN receive only: detect 11 or 12-bit breaks
// - LIN transmit only: send 11 or 12-bit break
// - Both LIN bits: detect and send, same length
// - Zero character never reported, real break reported
// - First prescaler divides by 1, 3, 4, 13
// - Baud divisor is two to field power
// - Reset clears baud divisor field to zero
// - One baud clock times receive and transmit
// - Second prescaler divides by code plus one
// - Code zero bypasses prescaler and fine adjust
// - Fine adjust inserts clocks per 32 cycles
// - Rate is source over 64 times divisors
// - Source is bus or oscillator clock
`timescale 1ns/1ps
`include "ubg_cfg.svh"
module ubg_baud_lin (
  input wire logic clk, // 40 MHz bus clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [2:0] avs_address, // Word index
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait, high except in the cycle after a request
  input wire logic oscillatorClock, // Oscillator clock, sampled
  input wire logic rxd, // Serial line input pin
  output logic txd, // Serial line output, idles high
  output logic sampleTick, // Pulse at sixteen times baud
  output logic bitTick, // Pulse once per bit time
  output logic breakFlag // Sticky break detected flag
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ubg_pkg::ubg_baud_ctl_type baudCtl;
  ubg_pkg::ubg_presc_ctl_type prescCtl;
  ubg_pkg::ubg_tx_state_type txState;
  logic moduleEnable, srcSel, longChar, sendReq, breakHit;
  logic oscS1, oscS2, oscS3, rxS1, rxS2;
  logic srcTick, preTick, stage1, stage2, sampleNext, bitNext;
  logic bypass, insertNow, restart, cfgWrite, busWr, armed;
  logic [3:0] pdCnt, pdLast, bpdCnt, txLeft;
  logic [4:0] fineAcc;
  logic [7:0] bdCnt, lowCnt, rxLimit;
  logic [1:0] sampCnt;
  logic [3:0] bitCnt;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders shared by the divider and its checks

  function automatic logic [3:0] bpdOf(input logic hi, input logic lo);
    logic [3:0] d;
    d = `UBG_BPD_CODE0;
    unique case ({hi, lo})
      2'b00: d = `UBG_BPD_CODE0;
      2'b01: d = `UBG_BPD_CODE1;
      2'b10: d = `UBG_BPD_CODE2;
      2'b11: d = `UBG_BPD_CODE3;
    endcase
    return d;
  endfunction

  function automatic logic [7:0] bdOf(input logic [2:0] sel);
    return 8'h01 << sel;
  endfunction

  // Break length in bits; non-LIN transmit keeps the plain break length
  function automatic logic [3:0] breakBits(input logic lin, input logic lng);
    if (lin)
      return lng ? `UBG_BREAK_LONG : `UBG_BREAK_SHORT;
    return lng ? `UBG_BREAK_SHORT : `UBG_BREAK_NORMAL;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the access completes

  assign busWr = ce && avs_write && !avs_waitrequest;
  assign cfgWrite = busWr && (avs_address == `UBG_IDX_BAUD || avs_address == `UBG_IDX_PRESC);

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if (ce)
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);

  // Read data loaded in the wait cycle so it stands when waitrequest is low
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (ce && avs_read && avs_waitrequest)
    begin
      unique case (avs_address)
        `UBG_IDX_BAUD: avs_readdata <= {24'h00_0000, baudCtl};
        `UBG_IDX_PRESC: avs_readdata <= {24'h00_0000, prescCtl};
        `UBG_IDX_CTRL: avs_readdata <= {29'h0000_0000, longChar, srcSel, moduleEnable};
        `UBG_IDX_STAT: avs_readdata <= {30'h0000_0000, txState != ubg_pkg::TX_IDLE, breakFlag};
        default: avs_readdata <= 32'h0000_0000; // Unmapped reads as zero
      endcase
    end

  // Rate registers; a write restarts the divider to avoid a torn period
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      baudCtl <= `UBG_BAUD_RESET;
      prescCtl <= `UBG_PRESC_RESET;
    end
    else if (busWr && avs_address == `UBG_IDX_BAUD)
      baudCtl <= {1'b0, avs_writedata[6:0]};
    else if (busWr && avs_address == `UBG_IDX_PRESC)
      prescCtl <= avs_writedata[7:0];

  // Control bits; the send request is a one-cycle strobe
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      moduleEnable <= 1'b0;
      srcSel <= 1'b0;
      longChar <= 1'b0;
      sendReq <= 1'b0;
    end
    else if (ce)
    begin
      sendReq <= busWr && avs_address == `UBG_IDX_CTRL && avs_writedata[`UBG_CTRL_SEND];
      if (busWr && avs_address == `UBG_IDX_CTRL)
      begin
        moduleEnable <= avs_writedata[`UBG_CTRL_ENABLE];
        srcSel <= avs_writedata[`UBG_CTRL_SRC];
        longChar <= avs_writedata[`UBG_CTRL_LONG];
      end
    end

  // Sticky break flag, write one to clear; a new break wins over the clear
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      breakFlag <= 1'b0;
    else if (ce && breakHit)
      breakFlag <= 1'b1;
    else if (busWr && avs_address == `UBG_IDX_STAT && avs_writedata[`UBG_STAT_BREAK])
      breakFlag <= 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two flops before any logic

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      oscS1 <= 1'b0;
      oscS2 <= 1'b0;
      oscS3 <= 1'b0;
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
    end
    else if (ce)
    begin
      oscS1 <= oscillatorClock;
      oscS2 <= oscS1;
      oscS3 <= oscS2;
      rxS1 <= rxd;
      rxS2 <= rxS1;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain: source, second prescaler with fine adjust, RATE_REGISTER_PRESCALE, BD

  // Oscillator source is limited to below half the bus clock by sampling
  assign srcTick = ce && moduleEnable && (srcSel ? (oscS2 && !oscS3) : 1'b1);
  assign restart = !moduleEnable || cfgWrite;
  assign bypass = prescCtl.prescalerDivisorSelect == 3'h0;
  assign pdLast = {1'b0, prescCtl.prescalerDivisorSelect} + {3'h0, insertNow};
  assign preTick = bypass ? srcTick : (srcTick && pdCnt == pdLast);
  assign stage1 = preTick
      && bpdCnt == bpdOf(baudCtl.ratePrescaleHi, baudCtl.ratePrescaleLo) - 4'h1;
  assign stage2 = stage1 && bdCnt == bdOf(baudCtl.baudDivisorSelect) - 8'h01;
  assign sampleNext = stage2 && sampCnt == `UBG_SAMPLE_LAST;
  assign bitNext = sampleNext && bitCnt == `UBG_BIT_LAST;

  // Second prescaler counter, one extra source clock when inserting
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      pdCnt <= 4'h0;
    else if (ce && restart)
      pdCnt <= 4'h0;
    else if (srcTick)
      pdCnt <= (preTick || bypass) ? 4'h0 : pdCnt + 4'h1;

  // Accumulator carry spreads the inserted clocks evenly over 32 periods
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {insertNow, fineAcc} <= 6'h00;
    else if (ce && restart)
      {insertNow, fineAcc} <= 6'h00;
    else if (preTick && !bypass)
      {insertNow, fineAcc} <= {1'b0, fineAcc} + {1'b0, prescCtl.clockInsertionSelect};

  // First prescaler and power-of-two divisor counters
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      bpdCnt <= 4'h0;
      bdCnt <= 8'h00;
    end
    else if (ce && restart)
    begin
      bpdCnt <= 4'h0;
      bdCnt <= 8'h00;
    end
    else if (preTick)
    begin
      bpdCnt <= stage1 ? 4'h0 : bpdCnt + 4'h1;
      if (stage1)
        bdCnt <= stage2 ? 8'h00 : bdCnt + 8'h01;
    end

  // Divide by 64 overall: four to the sample rate, sixteen to the bit rate
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      sampCnt <= 2'h0;
      bitCnt <= 4'h0;
      sampleTick <= 1'b0;
      bitTick <= 1'b0;
    end
    else if (ce)
    begin
      sampleTick <= sampleNext;
      bitTick <= bitNext;
      if (restart)
      begin
        sampCnt <= 2'h0;
        bitCnt <= 4'h0;
      end
      else if (stage2)
      begin
        sampCnt <= sampCnt + 2'h1;
        if (sampleNext)
          bitCnt <= bitCnt + 4'h1;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // LIN break detector, counts low samples at sixteen per bit

  // A zero character is at most ten and a bit low, so it never reaches 11 bits
  assign rxLimit = {breakBits(1'b1, longChar), 4'h0};
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      lowCnt <= 8'h00;
      armed <= 1'b1;
      breakHit <= 1'b0;
    end
    else if (ce)
    begin
      breakHit <= 1'b0;
      if (!baudCtl.linRxBreakEnable || restart)
      begin
        lowCnt <= 8'h00;
        armed <= 1'b1;
      end
      else if (sampleNext)
      begin
        if (rxS2)
        begin
          lowCnt <= 8'h00; // Ones must return before the next break
          armed <= 1'b1;
        end
        else if (armed && lowCnt == rxLimit - 8'h01)
        begin
          breakHit <= 1'b1;
          armed <= 1'b0;
          lowCnt <= 8'h00;
        end
        else if (armed)
          lowCnt <= lowCnt + 8'h01;
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // Break generator, aligned to bit ticks; requests while busy are dropped

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      txState <= ubg_pkg::TX_IDLE;
      txLeft <= 4'h0;
      txd <= 1'b1;
    end
    else if (ce)
    begin
      if (!moduleEnable)
      begin
        txState <= ubg_pkg::TX_IDLE;
        txd <= 1'b1;
      end
      else
      begin
        unique case (txState)
          ubg_pkg::TX_IDLE:
            if (sendReq)
              txState <= ubg_pkg::TX_ARM;
          ubg_pkg::TX_ARM:
            if (bitNext)
            begin
              txd <= 1'b0;
              txLeft <= breakBits(baudCtl.linTxBreakEnable, longChar) - 4'h1;
              txState <= ubg_pkg::TX_LOW;
            end
          ubg_pkg::TX_LOW:
            if (bitNext)
            begin
              if (txLeft == 4'h0)
              begin
                txd <= 1'b1;
                txState <= ubg_pkg::TX_IDLE;
              end
              else
                txLeft <= txLeft - 4'h1;
            end
          default:
            txState <= ubg_pkg::TX_IDLE;
        endcase
      end
    end

  ////////////////////////////////////////////////////////////////////////////
  // Checks and the helper counters they read

  logic [3:0] srcSince, preSince, txLowBits;
  logic [7:0] s1Since;
  logic [4:0] frameCnt;
  logic [5:0] insCnt;
  logic frameSeen;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      srcSince <= 4'h0;
      preSince <= 4'h0;
      s1Since <= 8'h00;
      frameCnt <= 5'h00;
      insCnt <= 6'h00;
      frameSeen <= 1'b0;
    end
    else if (ce && restart)
    begin
      srcSince <= 4'h0;
      preSince <= 4'h0;
      s1Since <= 8'h00;
      frameCnt <= 5'h00;
      insCnt <= 6'h00;
      frameSeen <= 1'b0;
    end
    else if (srcTick)
    begin
      srcSince <= preTick ? 4'h0 : srcSince + 4'h1;
      if (preTick)
      begin
        preSince <= stage1 ? 4'h0 : preSince + 4'h1;
        frameCnt <= frameCnt + 5'h01;
        insCnt <= (frameCnt == `UBG_FRAME_LAST) ? 6'h00 : insCnt + {5'h00, insertNow};
        if (frameCnt == `UBG_FRAME_LAST)
          frameSeen <= 1'b1;
      end
      if (stage1)
        s1Since <= stage2 ? 8'h00 : s1Since + 8'h01;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      txLowBits <= 4'h0;
    else if (ce && txState == ubg_pkg::TX_ARM)
      txLowBits <= 4'h0;
    else if (ce && !txd && bitNext)
      txLowBits <= txLowBits + 4'h1;

  sequence s_break_start;
    ce && $fell(txd);
  endsequence
  sequence s_break_held;
    !txd [*8];
  endsequence

  a_divisor_reset: assert property ($rose(rst_n) |-> baudCtl.baudDivisorSelect == 3'h0)
    else $error("baud divisor field not zero after reset");
  a_bypass_pass: assert property (bypass |-> preTick == srcTick && !insertNow)
    else $error("bypass does not pass source clock untouched");
  a_pd_period: assert property (preTick && !bypass |-> srcSince == pdLast)
    else $error("second prescaler period wrong");
  a_bpd_period: assert property (stage1 |->
      preSince + 4'h1 == bpdOf(baudCtl.ratePrescaleHi, baudCtl.ratePrescaleLo))
    else $error("first prescaler period wrong");
  a_bd_period: assert property (stage2 |-> s1Since + 8'h01 == bdOf(baudCtl.baudDivisorSelect))
    else $error("power of two divisor period wrong");
  a_fine_frame: assert property (preTick && !bypass && frameSeen && frameCnt == `UBG_FRAME_LAST
      |-> insCnt + {5'h00, insertNow} == {1'b0, prescCtl.clockInsertionSelect})
    else $error("inserted clock count per frame wrong");
  a_fine_spread: assert property (preTick && insertNow && !restart
      && prescCtl.clockInsertionSelect <= `UBG_SPREAD_MAX |=> !insertNow)
    else $error("inserted clocks bunched together");
  a_one_clock: assert property (bitTick |-> sampleTick && $past(stage2))
    else $error("bit tick not on a sample tick");
  a_rx_break: assert property (breakHit |->
      $past(lowCnt) == rxLimit - 8'h01 && !$past(rxS2) && baudCtl.linRxBreakEnable)
    else $error("break reported at wrong length");
  a_tx_held: assert property (s_break_start |-> s_break_held)
    else $error("break output released early");
  a_tx_bits: assert property (ce && $rose(txd) && moduleEnable |->
      txLowBits == breakBits(baudCtl.linTxBreakEnable, longChar))
    else $error("break length in bits wrong");
  a_bus_answer: assert property (ce && (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
    else $error("bus answer not one cycle later");

endmodule // ubg_baud_lin

// >>> ubg_line_node.sv
// Far-side LIN node model: drives the receive line and times low runs on the line it hears
`timescale 1ns/1ps
module ubg_line_node (
  input wire logic clk, // Bench clock
  input wire logic txd, // Line driven by the block
  output logic rxd // Line driven toward the block
);
  int lowRun = 0;
  int lastLowLen = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Line is pulled high whenever this node is not pulling it low
  initial
  begin
    rxd = 1'b1;
  end
  // Pull the line low for a number of clocks, then release to the idle level
  task automatic send_low(input int n);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (n) @(posedge clk);
    rxd <= 1'b1;
  endtask
  // Length of each low run is timed here, since hardware detection only filters
  always @(posedge clk)
  begin
    if (txd === 1'b0)
      lowRun <= lowRun + 1;
    else if (lowRun != 0)
    begin
      lastLowLen <= lowRun;
      lowRun <= 0;
    end
  end
endmodule // ubg_line_node

// >>> tb_top.sv
// Self-checking bench for the baud generator and LIN break logic
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic [2:0] avsAddress = 3'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h00000000;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic osc = 1'b0;
  logic [1:0] oscDiv = 2'h0;
  logic rxd;
  logic txd;
  logic sampleTick;
  logic bitTick;
  logic breakFlag;
  logic [31:0] rd;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 58;
  int gap;
  int sum;
  int k;
  int n;
  logic ok;
  int bLen[6] = '{1035, 1105, 1150, 1205, 1500, 1205};
  logic [7:0] bB0[6] = '{8'h20, 8'h20, 8'h20, 8'h20, 8'h00, 8'h60};
  logic [7:0] bCtl[6] = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h01, 8'h05};
  logic bExp[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int bpdTab[4] = '{1, 3, 4, 13};
  ////////////////////////////////////////////////////////////////////////////////
  ubg_baud_lin i_dut (
    .clk(clk),
    .rst_n(rstN),
    .ce(1'b1),
    .avs_address(avsAddress),
    .avs_read(avsRead),
    .avs_write(avsWrite),
    .avs_writedata(avsWritedata),
    .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest),
    .oscillatorClock(osc),
    .rxd(rxd),
    .txd(txd),
    .sampleTick(sampleTick),
    .bitTick(bitTick),
    .breakFlag(breakFlag)
  );
  ubg_line_node i_node (
    .clk(clk),
    .txd(txd),
    .rxd(rxd)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    forever #12.5 clk = !clk;
  end
  // Oscillator source at one eighth of the clock, well below the sync limit
  always @(posedge clk)
  begin
    oscDiv <= oscDiv + 2'h1;
    if (oscDiv == 2'h3)
      osc <= !osc;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // A wait that runs out ends the run, so a hang never stalls the bench
  task automatic limit(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      fail_count++;
      $display("[FAIL] wait expected below %0d seen %0d", lim, cnt);
      print_verdict();
    end
  endtask
  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic isWr, input logic [2:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int c;
    c = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= isWr;
    avsRead <= !isWr;
    avsWritedata <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      c++;
    end while (avsWaitrequest !== 1'b0 && c < 50);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    limit(c, 50);
  endtask
  // Edges until the next tick is sampled high
  task automatic wait_tick(input bit useBit, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
    end while ((useBit ? bitTick : sampleTick) !== 1'b1 && cnt < 20000);
    limit(cnt, 20000);
  endtask
  task automatic wait_line(input logic lvl);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (txd !== lvl && n < 2000);
    limit(n, 2000);
  endtask
  // Module is disabled around every rate change, bypass switches included
  task automatic set_rate(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] ctl);
    bus(1'b1, 3'h2, 8'h00, rd);
    bus(1'b1, 3'h0, b0, rd);
    bus(1'b1, 3'h1, b1, rd);
    bus(1'b1, 3'h2, ctl, rd);
    wait_tick(1'b0, gap);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    rstN <= 1'b1;
    // Baud reset value, unmapped read and field readback
    bus(1'b0, 3'h0, 8'h00, rd);
    check("baud reset", rd, 32'h00000000);
    bus(1'b0, 3'h5, 8'h00, rd);
    check("unmapped", rd, 32'h00000000);
    k = $random(seed) & 255;
    bus(1'b1, 3'h1, k[7:0], rd);
    bus(1'b0, 3'h1, 8'h00, rd);
    check("presc rw", rd, k);
    bus(1'b1, 3'h0, 8'hFF, rd);
    bus(1'b0, 3'h0, 8'h00, rd);
    check("baud rw", rd, 32'h0000007F);
    $display("test registers done");
    // Divider chain: every code of the first prescaler, baud divisor and second prescaler fields
    for (int i = 0; i < 4; i++)
    begin
      set_rate({3'h0, i[1:0], 3'h0}, 8'h00, 8'h01);
      wait_tick(1'b0, gap);
      check("first prescaler", gap, 4 * bpdTab[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      set_rate({5'h00, i[2:0]}, 8'h00, 8'h01);
      wait_tick(1'b0, gap);
      check("baud divisor", gap, 4 << i);
    end
    for (int i = 0; i < 8; i++)
    begin
      // Fine adjust only in bypass here, where it must be ignored
      set_rate(8'h00, {i[2:0], (i == 0) ? 5'h1F : 5'h00}, 8'h01);
      wait_tick(1'b0, gap);
      check("second prescaler", gap, (i == 0) ? 4 : 4 * (i + 1));
    end
    $display("test dividers done");
    // Fine adjust over whole frames, and its spread within a frame
    for (int r = 0; r < 3; r++)
    begin
      k = $random(seed) & 31;
      set_rate(8'h00, {3'h1, k[4:0]}, 8'h01);
      repeat (8) wait_tick(1'b0, gap);
      sum = 0;
      ok = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
        wait_tick(1'b0, gap);
        sum += gap;
        ok &= (gap >= 8 + k / 8) && (gap <= 9 + k / 8);
      end
      check("fine frame", sum, 64 + k);
      check("fine spread", ok, 1);
    end
    set_rate(8'h09, 8'h50, 8'h01);
    wait_tick(1'b1, gap);
    wait_tick(1'b1, gap);
    check("bit period", gap, 64 * 3 * 2 * 7 / 2);
    set_rate(8'h00, 8'h00, 8'h03);
    wait_tick(1'b0, gap);
    check("osc source", gap, 32);
    $display("test rate done");
    // Break detection against zero characters and real breaks
    for (int i = 0; i < 6; i++)
    begin
      set_rate(bB0[i], 8'h00, bCtl[i]);
      i_node.send_low(bLen[i] * 64 / 100);
      repeat (30) @(posedge clk);
      check("break pin", breakFlag, bExp[i]);
      bus(1'b0, 3'h3, 8'h00, rd);
      check("break status", rd[0], bExp[i]);
      bus(1'b1, 3'h3, 8'h01, rd);
    end
    $display("test detect done");
    // Break generation for each length selection
    for (int i = 0; i < 4; i++)
    begin
      set_rate({1'b0, i[1], i[1] & i[0], 5'h00}, 8'h00, {5'h00, i[0], 2'h1});
      bus(1'b1, 3'h2, {4'h0, 1'b1, i[0], 2'h1}, rd);
      bus(1'b0, 3'h3, 8'h00, rd);
      check("sending flag", rd[1], 1'b1);
      wait_line(1'b0);
      wait_line(1'b1);
      @(posedge clk);
      k = i[1] ? (i[0] ? 12 : 11) : (i[0] ? 11 : 10);
      check("break length", i_node.lastLowLen, 64 * k);
      bus(1'b0, 3'h3, 8'h00, rd);
      check("sending done", rd[1], 1'b0);
    end
    $display("test send done");
    print_verdict();
  end
endmodule // tb_top
